/* File: dv/ddp_mem_model.sv */
`timescale 1ns/10ps
module ddp_mem_model (
  input  wire        dqs_o,  // write strobe
  input  wire [17:0] dq_o,   // data from device
  input  wire        dq_oe,  // data enable
  input  wire [1:0]  dm,     // mask per group
  output reg  [17:0] dq_i,   // data to device
  output reg  [1:0]  dqs_i,  // read strobe
  output reg         rclk_i, // read clock
  output reg  [17:0] mem_b0, // stored first beat
  output reg  [17:0] mem_b1  // stored second beat
);
  function [17:0] merge(input [17:0] old, input [17:0] d, input [1:0] m);
    merge = {m[1] ? old[17:9] : d[17:9], m[0] ? old[8:0] : d[8:0]};
  endfunction
  initial
  begin
    dq_i = 18'h0;
    dqs_i = 2'h0;
    rclk_i = 1'b0;
    mem_b0 = 18'h0;
    mem_b1 = 18'h0;
  end
  // strobe fall is mid first beat; second beat sampled 20 ns after it starts
  always @(negedge dqs_o)
  begin
    if (dq_oe)
      mem_b0 = merge(mem_b0, dq_o, dm);
    #100;
    if (dq_oe)
      mem_b1 = merge(mem_b1, dq_o, dm);
  end
  // one read frame; reference stands low outside it, data shows no stale value
  task burst(input [17:0] r, input [17:0] f, input sel);
    begin
      dq_i = r;
      rclk_i = sel;
      dqs_i = {2{~sel}};
      #160;
      dq_i = f;
      rclk_i = 1'b0;
      dqs_i = 2'h0;
      #160;
      dq_i = ~f;
    end
  endtask
endmodule // ddp_mem_model

/* File: dv/ddp_phy_sva.sv */
`timescale 1ns/10ps
module ddp_phy_sva #(
  parameter NGRP  = 2,
  parameter LARGE = 1'b0
) (
  input wire        sys_clk,      // clock
  input wire        srst,         // reset
  input wire        wide_en,      // 16-bit
  input wire        par_en,       // parity
  input wire        qdr_mode,     // quad-rate
  input wire        rd_src_sel,   // read ref
  input wire [1:0]  dqs_i,        // strobe in
  input wire        rd_valid_r,   // read pulse
  input wire        grp_cfg_ok_r, // group limit
  input wire        sys_ck_r,     // sys clock
  input wire        wr_ck_r,      // write clock
  input wire [17:0] dq_o_r,       // data out
  input wire [17:0] dq_oe_r,      // data oe
  input wire [1:0]  dm_r,         // mask
  input wire [1:0]  dqs_o_r,      // strobe out
  input wire [1:0]  dqs_oe_r      // strobe oe
);
  wire g1_off = qdr_mode | ~wide_en;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // ********
  // pin timing
  // ********
  sequence s_ck_half;
    sys_ck_r [*4] ##1 !sys_ck_r;
  endsequence
  sequence s_dqs_half;
    dqs_o_r[0] [*4] ##1 !dqs_o_r[0];
  endsequence
  a_ck_period: assert property ($rose(sys_ck_r) |-> s_ck_half)
    else $error("system clock high time wrong");
  a_wck_lag: assert property (!$past(srst) && !$past(srst, 2)
    |-> wr_ck_r == $past(sys_ck_r, 2)) else $error("write clock lag wrong");
  a_strobe_len: assert property ($rose(dqs_o_r[0]) |-> s_dqs_half)
    else $error("write strobe high time wrong");
  a_beat_hold: assert property ($rose(dqs_o_r[0]) |-> ##3 $stable(dq_o_r) [*3])
    else $error("first beat not held");
  a_par_bit: assert property (par_en && $past(par_en) && dq_oe_r[8]
    |-> dq_o_r[8] == ^dq_o_r[7:0]) else $error("parity pin wrong");
  a_grp1_off: assert property (g1_off && $past(g1_off)
    |-> dm_r[1] && dq_oe_r[17:9] == 9'h000) else $error("group1 not disabled");
  a_dm_idle: assert property (!dqs_oe_r[0] && !$past(dqs_oe_r[0]) && !$past(dqs_oe_r[0], 2)
    |-> dm_r == 2'h3) else $error("mask low while idle");
  a_rd_pulse: assert property (rd_valid_r |=> !rd_valid_r)
    else $error("read pulse too long");
  a_rd_answer: assert property ($fell(dqs_i[0]) && !rd_src_sel
    |-> ##[3:24] rd_valid_r) else $error("no read word after strobe");
  a_cfg_ok: assert property (!$past(srst)
    |-> grp_cfg_ok_r == (NGRP <= (LARGE ? 14 : 6))) else $error("group limit flag wrong");
endmodule // ddp_phy_sva

bind ddp_phy ddp_phy_sva #(.NGRP(NGRP), .LARGE(LARGE)) u_sva (.sys_clk(sys_clk), .srst(srst),
  .wide_en(wide_en), .par_en(par_en), .qdr_mode(qdr_mode), .rd_src_sel(rd_src_sel),
  .dqs_i(dqs_i), .rd_valid_r(rd_valid_r), .grp_cfg_ok_r(grp_cfg_ok_r), .sys_ck_r(sys_ck_r),
  .wr_ck_r(wr_ck_r), .dq_o_r(dq_o_r), .dq_oe_r(dq_oe_r), .dm_r(dm_r), .dqs_o_r(dqs_o_r),
  .dqs_oe_r(dqs_oe_r));

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        wide_en = 1'b0;
  logic        ninth_en = 1'b0;
  logic        par_en = 1'b0;
  logic        qdr_mode = 1'b0;
  logic        rd_src_sel = 1'b0;
  logic        wr_valid = 1'b0;
  logic [3:0]  rd_dly = 4'h0;
  logic [3:0]  wr_mask = 4'h0;
  logic [35:0] wr_data = 36'h0;
  wire         wr_ready, rd_valid_r, grp_cfg_ok_r, sys_ck_r, wr_ck_r, rclk_i;
  wire  [35:0] rd_data_r;
  wire  [17:0] dq_o_r, dq_oe_r, dq_i, mem_b0, mem_b1;
  wire  [1:0]  dm_r, dqs_o_r, dqs_oe_r, dqs_i;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cyc = 0;
  ddp_phy uut (.sys_clk(sys_clk), .srst(srst), .wide_en(wide_en), .ninth_en(ninth_en),
    .par_en(par_en), .qdr_mode(qdr_mode), .rd_src_sel(rd_src_sel), .rd_dly(rd_dly),
    .wr_data(wr_data), .wr_mask(wr_mask), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .grp_cfg_ok_r(grp_cfg_ok_r),
    .sys_ck_r(sys_ck_r), .wr_ck_r(wr_ck_r), .dq_o_r(dq_o_r), .dq_oe_r(dq_oe_r),
    .dq_i(dq_i), .dm_r(dm_r), .dqs_o_r(dqs_o_r), .dqs_oe_r(dqs_oe_r), .dqs_i(dqs_i),
    .rclk_i(rclk_i));
  ddp_mem_model mem (.dqs_o(dqs_o_r[0]), .dq_o(dq_o_r), .dq_oe(dq_oe_r[0]), .dm(dm_r),
    .dq_i(dq_i), .dqs_i(dqs_i), .rclk_i(rclk_i), .mem_b0(mem_b0), .mem_b1(mem_b1));
  always #20 sys_clk = ~sys_clk;
  task wrap_up;
    begin
      $display("mismatches %0d of %0d checks", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    begin
      tests_run++;
      if (g !== e)
      begin
        miscompares++;
        $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // ********
  // write helpers: valid stays up between pushes
  // ********
  task push(input logic [35:0] d, input logic [3:0] m);
    begin
      wr_data <= d;
      wr_mask <= m;
      wr_valid <= 1'b1;
      do @(posedge sys_clk); while (wr_ready !== 1'b1);
    end
  endtask
  task idle;
    begin
      wr_valid <= 1'b0;
      repeat (48) @(posedge sys_clk);
    end
  endtask
  task t_write16;
    logic [35:0] a, b;
    begin
      a = 36'h9a5c31e2d;
      b = 36'h3c96e5b17;
      wide_en <= 1'b1;
      ninth_en <= 1'b1;
      @(posedge sys_clk);
      push(a, 4'h0);
      push(b, 4'h6);
      idle;
      chk("beat0", {a[17:9], b[8:0]}, mem_b0);
      chk("beat1", {b[35:27], a[26:18]}, mem_b1);
    end
  endtask
  // byte mode with parity, or quad-rate with group1 off
  task t_g1off(input logic q);
    logic [35:0] d;
    logic [17:0] o0, o1;
    begin
      d = 36'h5e3b7c9a7;
      o0 = mem_b0;
      o1 = mem_b1;
      wide_en <= q;
      qdr_mode <= q;
      ninth_en <= q;
      par_en <= ~q;
      @(posedge sys_clk);
      push(d, 4'h0);
      idle;
      chk("g1off_beat0", {o0[17:9], (q ? d[8] : ^d[7:0]), d[7:0]}, mem_b0);
      chk("g1off_beat1", {o1[17:9], (q ? d[26] : ^d[25:18]), d[25:18]}, mem_b1);
      qdr_mode <= 1'b0;
      par_en <= 1'b0;
    end
  endtask
  task t_read(input logic sel, input logic [3:0] dly);
    int i;
    logic [17:0] r, f;
    begin
      r = 18'h2a5c3 ^ {13'h0, sel, dly};
      f = 18'h15a3c ^ {dly, 13'h0, sel};
      rd_src_sel <= sel;
      rd_dly <= dly;
      wide_en <= 1'b1;
      @(posedge sys_clk);
      #7 mem.burst(r, f, sel);
      for (i = 0; i < 20 && rd_valid_r !== 1'b1; i++)
        @(negedge sys_clk);
      chk("rd_valid", 36'h1, {35'h0, rd_valid_r});
      chk("rd_data", {f, r}, rd_data_r);
    end
  endtask
  task t_full;
    int n;
    begin
      n = 0;
      wr_valid <= 1'b1;
      repeat (12)
      begin
        @(posedge sys_clk);
        n += (wr_ready === 1'b0);
      end
      idle;
      chk("refused", 36'h1, n > 0);
      chk("drained", 36'h1, wr_ready);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("dm_idle", 36'h3, dm_r);
    chk("grp_ok", 36'h1, grp_cfg_ok_r);
    t_write16;
    t_g1off(1'b0);
    t_g1off(1'b1);
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 3; k += 2)
        t_read(s[0], k[3:0]);
    t_full;
    wrap_up;
  end
endmodule // tb_top

/* File: rtl/ddp_defines.vh */
// Notes on behaviour
// - each group runs byte-wide with optional ninth bit, or 16-bit with optional 18.
// - a group is one strobe pin, one mask pin and up to nine data pins.
// - with parity on, one parity bit per eight data bits, on a chosen pin.
// - mask pin low writes the data, high makes the memory discard it.
// - every strobe and data group has its own mask output.
// - two clock outputs are made: a system clock and a write clock.
// - write clock lags system clock by a quarter period and launches write data.
// - system clock phase launches write strobes, commands and addresses.
// - incoming strobe edges are delayed by a programmable count to centre them.
// - delayed strobe edges clock the capture registers of their data pins; here strobe 0 alone times both groups.
// - read reference is either the two-way strobe or a one-way read clock.
// - interface rated to 167 MHz; 333 Mbps double-rate, 667 Mbps quad-rate.
// - a nine-bit group may run byte-wide, an eighteen-bit group 16-bit.
// - quad-rate write data on group pins halves usable nine and eighteen groups.
// - at most 6 groups on small packages, 14 on large ones.
`ifndef DDP_DEFINES_VH
`define DDP_DEFINES_VH

// ************************************************
// geometry
// ************************************************
`define DDP_GRP_PINS     9
`define DDP_GRP_DATA     8
`define DDP_NGRP         2
`define DDP_PAR_PIN      8
`define DDP_MAX_GRP_SML  6
`define DDP_MAX_GRP_LRG  14

// ************************************************
// rates and timing
// ************************************************
`define DDP_MAX_MHZ      167
`define DDP_DDR_MBPS     333
`define DDP_QDR_MBPS     667
`define DDP_DDR_BEATS    2
`define DDP_QDR_BEATS    4
`define DDP_SYS_MHZ      25
`define DDP_LINK_NS      320
`define DDP_SYS_NS       40
`define DDP_DIV          (`DDP_LINK_NS / `DDP_SYS_NS)
`define DDP_QTR_DIV      4
`define DDP_FIFO_DEPTH   4
`define DDP_DLY_W        4

`endif

/* File: rtl/ddp_fifo.v */
`timescale 1ns/10ps
`include "ddp_defines.vh"

module ddp_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = `DDP_FIFO_DEPTH,
  parameter AW    = 2
) (
  input  wire             sys_clk,   // clock
  input  wire             srst,      // sync reset
  input  wire [WIDTH-1:0] in_data,   // fill data
  input  wire             in_valid,  // fill valid
  output reg              in_ready,  // room left
  output wire [WIDTH-1:0] out_data,  // head word
  output reg              out_valid, // not empty
  input  wire             out_ready  // drain
);

  reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg  [AW-1:0]    wp_r;
  reg  [AW-1:0]    rp_r;
  reg  [AW:0]      cnt_r;
  wire             push;
  wire             pop;
  wire [AW:0]      cnt_nxt;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign cnt_nxt  = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_r[rp_r];

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      wp_r      <= {AW{1'b0}};
      rp_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data;
        wp_r        <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
        rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
      cnt_r     <= cnt_nxt;
      in_ready  <= (cnt_nxt != DEPTH);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end

endmodule // ddp_fifo

/* File: rtl/ddp_phy.v */
`timescale 1ns/10ps
`include "ddp_defines.vh"

module ddp_phy #(
  parameter DIV     = `DDP_DIV,
  parameter LARGE   = 1'b0,
  parameter NGRP    = `DDP_NGRP,
  parameter DLY_W   = `DDP_DLY_W
) (
  input  wire                   sys_clk,     // system clock, 25 MHz
  input  wire                   srst,        // sync reset, active high
  // user side
  input  wire                   wide_en,     // 16-bit mode, else byte-wide
  input  wire                   ninth_en,    // drive ninth bit of each group
  input  wire                   par_en,      // ninth bit carries parity
  input  wire                   qdr_mode,    // quad-rate mode; only turns the upper group off
  input  wire                   rd_src_sel,  // 0 strobe, 1 read clock
  input  wire [DLY_W-1:0]       rd_dly,      // strobe delay in sys cycles
  input  wire [35:0]            wr_data,     // beat1[35:18], beat0[17:0]
  input  wire [3:0]             wr_mask,     // beat1[3:2], beat0[1:0], per group
  input  wire                   wr_valid,    // write word offered
  output wire                   wr_ready,    // write word taken
  output reg  [35:0]            rd_data_r,   // fall[35:18], rise[17:0]
  output reg                    rd_valid_r,  // read word pulse
  output reg                    grp_cfg_ok_r,// group count and rates within limits
  // memory pins
  output reg                    sys_ck_r,    // system clock out
  output reg                    wr_ck_r,     // write clock out
  output reg  [17:0]            dq_o_r,      // data out
  output reg  [17:0]            dq_oe_r,     // data drive enable
  input  wire [17:0]            dq_i,        // data in
  output reg  [1:0]             dm_r,        // data mask per group
  output reg  [1:0]             dqs_o_r,     // strobe out
  output reg  [1:0]             dqs_oe_r,    // strobe drive enable
  input  wire [1:0]             dqs_i,       // strobe in
  input  wire                   rclk_i       // one-way read clock in
);

  // ************************************************
  // phases of one link period
  // ************************************************
  localparam QTR     = DIV / `DDP_QTR_DIV;
  localparam PH_SR   = 0;
  localparam PH_DR   = QTR;
  localparam PH_SF   = 2 * QTR;
  localparam PH_DF   = 3 * QTR;
  localparam PH_LAST = DIV - 1;
  localparam GRP_MAX = LARGE ? `DDP_MAX_GRP_LRG : `DDP_MAX_GRP_SML;
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // ************************************************
  // rate limits
  // ************************************************
  // the pin clock is the system clock divided down; it must stay within
  // the rated clock and the rated per-pin data rates
  localparam PIN_MHZ  = `DDP_SYS_MHZ / DIV;
  localparam DDR_MBPS = `DDP_DDR_BEATS * PIN_MHZ;
  localparam QDR_MBPS = `DDP_QDR_BEATS * PIN_MHZ;
  localparam RATE_OK  = (PIN_MHZ <= `DDP_MAX_MHZ) &&
                        (DDR_MBPS <= `DDP_DDR_MBPS) &&
                        (QDR_MBPS <= `DDP_QDR_MBPS);
  // groups and rates both within limits
  localparam CFG_OK   = (NGRP <= GRP_MAX) && RATE_OK;

  reg  [7:0]   ph_r;
  reg          st_r;
  reg  [35:0]  cur_data_r;
  reg  [3:0]   cur_mask_r;
  wire [39:0]  ff_dout;
  wire         ff_valid;
  wire         ff_pop;
  wire         grp1_on;
  reg  [17:0]  beat_d;
  reg  [1:0]   beat_m;
  reg  [17:0]  oe_pat;

  // ************************************************
  // write buffer
  // ************************************************
  assign ff_pop = (ph_r == PH_LAST);

  ddp_fifo #(
    .WIDTH (40),
    .DEPTH (`DDP_FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_data   ({wr_mask, wr_data}),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (ff_dout),
    .out_valid (ff_valid),
    .out_ready (ff_pop)
  );

  // ************************************************
  // group configuration
  // ************************************************
  // upper group only in 16-bit mode, and lost when quad-rate halves the count
  assign grp1_on = wide_en & ~qdr_mode;

  always @*
  begin
    oe_pat        = 18'h00000;
    oe_pat[7:0]   = 8'hff;
    oe_pat[8]     = ninth_en | par_en;
    oe_pat[16:9]  = grp1_on ? 8'hff : 8'h00;
    oe_pat[17]    = grp1_on & (ninth_en | par_en);
  end

  // beat select with optional parity on the ninth pin of each group
  always @*
  begin
    beat_d = (ph_r < PH_SF) ? cur_data_r[17:0] : cur_data_r[35:18];
    beat_m = (ph_r < PH_SF) ? cur_mask_r[1:0] : cur_mask_r[3:2];
    if (par_en)
    begin
      beat_d[`DDP_PAR_PIN]     = ^beat_d[7:0];
      beat_d[`DDP_PAR_PIN + 9] = ^beat_d[16:9];
    end
  end

  // ************************************************
  // clock outputs and write launch
  // ************************************************
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ph_r         <= 8'h00;
      st_r         <= ST_IDLE;
      cur_data_r   <= 36'h000000000;
      cur_mask_r   <= 4'hf;
      sys_ck_r     <= 1'b0;
      wr_ck_r      <= 1'b0;
      dq_o_r       <= 18'h00000;
      dq_oe_r      <= 18'h00000;
      dm_r         <= 2'h3;
      dqs_o_r      <= 2'h0;
      dqs_oe_r     <= 2'h0;
      grp_cfg_ok_r <= 1'b0;
    end
    else
    begin
      ph_r <= (ph_r == PH_LAST) ? 8'h00 : ph_r + 8'h01;
      grp_cfg_ok_r <= CFG_OK;
      // two clocks, the write clock a quarter period behind
      sys_ck_r <= (ph_r >= PH_SR) && (ph_r < PH_SF);
      wr_ck_r  <= (ph_r >= PH_DR) && (ph_r < PH_DF);
      case (st_r)
        ST_IDLE:
        begin
          dqs_oe_r <= 2'h0;
          dq_oe_r  <= 18'h00000;
          dm_r     <= 2'h3;
          if (ff_pop && ff_valid)
          begin
            cur_data_r <= ff_dout[35:0];
            cur_mask_r <= ff_dout[39:36];
            st_r       <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          // strobes on the system clock phase
          if (ph_r == PH_SR)
          begin
            dqs_oe_r <= {grp1_on, 1'b1};
            dqs_o_r  <= {grp1_on, 1'b1};
          end
          if (ph_r == PH_SF)
            dqs_o_r <= 2'h0;
          // data and mask on the write clock phase
          if ((ph_r == PH_DR) || (ph_r == PH_DF))
          begin
            dq_o_r  <= beat_d;
            dq_oe_r <= oe_pat;
            dm_r    <= {beat_m[1] | ~grp1_on, beat_m[0]};
          end
          if (ff_pop)
          begin
            if (ff_valid)
            begin
              cur_data_r <= ff_dout[35:0];
              cur_mask_r <= ff_dout[39:36];
            end
            else
              st_r <= ST_IDLE;
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ************************************************
  // read reference and data synchronisers
  // ************************************************
  reg  [2:0]   strb_s_r;
  reg  [2:0]   rclk_s_r;
  reg  [17:0]  dq_s1_r;
  reg  [17:0]  dq_s2_r;
  reg  [17:0]  dq_s3_r;
  reg          ref_lvl_r;
  wire         ref_s2;
  wire         ref_s3;
  wire         ref_edge;

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      strb_s_r <= 3'h0;
      rclk_s_r <= 3'h0;
    end
    else
    begin
      strb_s_r <= {strb_s_r[1:0], dqs_i[0]};
      rclk_s_r <= {rclk_s_r[1:0], rclk_i};
    end
  end

  // ************************************************
  // data synchroniser
  // ************************************************
  // same depth as the reference path, so a delayed edge
  // sees the data that stood beside it at the pins
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      dq_s1_r  <= 18'h00000;
      dq_s2_r  <= 18'h00000;
      dq_s3_r  <= 18'h00000;
    end
    else
    begin
      dq_s1_r  <= dq_i;
      dq_s2_r  <= dq_s1_r;
      dq_s3_r  <= dq_s2_r;
    end
  end

  // reference is the two-way strobe or the read clock
  assign ref_s2   = rd_src_sel ? rclk_s_r[1] : strb_s_r[1];
  assign ref_s3   = rd_src_sel ? rclk_s_r[2] : strb_s_r[2];
  assign ref_edge = (ref_s2 == ref_s3) && (ref_s3 != ref_lvl_r);

  // ************************************************
  // delayed capture on both edges
  // ************************************************
  reg  [DLY_W-1:0] dly_cnt_r;
  reg              dly_busy_r;
  reg              dly_fall_r;
  reg  [17:0]      cap_rise_r;
  wire             dly_hit;

  assign dly_hit = dly_busy_r && (dly_cnt_r == rd_dly);

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ref_lvl_r  <= 1'b0;
      dly_cnt_r  <= {DLY_W{1'b0}};
      dly_busy_r <= 1'b0;
      dly_fall_r <= 1'b0;
      cap_rise_r <= 18'h00000;
      rd_data_r  <= 36'h000000000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= 1'b0;
      if (ref_edge)
      begin
        ref_lvl_r  <= ref_s3;
        dly_busy_r <= 1'b1;
        dly_fall_r <= ~ref_s3;
        dly_cnt_r  <= {DLY_W{1'b0}};
      end
      else if (dly_busy_r && !dly_hit)
        dly_cnt_r <= dly_cnt_r + 1'b1;
      // delayed edge clocks the capture registers
      if (dly_hit && !ref_edge)
      begin
        dly_busy_r <= 1'b0;
        if (!dly_fall_r)
          cap_rise_r <= dq_s3_r;
        else
        begin
          rd_data_r[17:0]  <= grp1_on ? cap_rise_r : {9'h000, cap_rise_r[8:0]};
          rd_data_r[35:18] <= grp1_on ? dq_s3_r : {9'h000, dq_s3_r[8:0]};
          rd_valid_r       <= 1'b1;
        end
      end
    end
  end

endmodule // ddp_phy
